// ===== common/umc_pkg.sv
// ****************************************
// shared definitions
// ****************************************
package umc_pkg;

	// register map: byte addresses
	localparam logic [7:0] MODE_ADDR   = 8'h00;
	localparam logic [7:0] STATUS_ADDR = 8'h04;

	// field positions in the mode register
	localparam int SLEEP_RUN_BIT = 23;
	localparam int ACTIVE_BIT    = 22;
	localparam int CLKSRC_LO     = 17;
	localparam int RUN_ON_OVERFLOW_BIT    = 16;
	localparam int ENABLE_BIT    = 15;
	localparam int STOP_IDLE_BIT = 13;
	localparam int PIN_EN_LO     = 8;

	// writable bits: 23, 18:15, 13:0
	localparam logic [31:0] MODE_WMASK = 32'h0087_bfff;
	localparam logic [31:0] MODE_RESET = 32'h0000_0000;

	// status register bits of own choosing
	localparam int ST_BRG_RUN_BIT  = 0;
	localparam int ST_CHAN_RUN_BIT = 1;
	localparam int ST_OVR_BIT      = 2;
	localparam int ST_PINS_BIT     = 3;

	typedef enum logic [1:0] {
		CLK_PB2_SLEEPOFF = 2'b00,
		CLK_SYS_SLEEPOFF = 2'b01,
		CLK_FAST_OSC     = 2'b10,
		CLK_PB2          = 2'b11
	} umc_clksrc_t;

	typedef struct packed {
		logic sleep_mode;
		logic deep_sleep_mode;
		logic idle_mode;
	} umc_power_t;

	typedef struct packed {
		logic brg_clk_run;
		logic [1:0] brg_clk_sel;
		logic chan_run;
	} umc_clkctl_t;

	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
	localparam logic [2:0] HSIZE_WORD    = 3'b010;

endpackage : umc_pkg

// ===== rtl/umc_mode_ctrl.sv
// Operation
// - with sleep-run set the generator clock keeps running in sleep, otherwise it stops.
// - sleep-run only counts when the fast internal oscillator is the selected source.
// - deep sleep stops every clock and the channel whatever sleep-run says.
// - the activity bit is read-only hardware status, one while the channel runs and is busy.
// - the two-bit source field picks bus clock two, fast oscillator or system clock.
// - with run-on-overflow set the receive shifter keeps shifting after an overrun.
// - with run-on-overflow clear the receive shifter stops taking data after an overrun.
// - when enabled the channel owns its pins per pin-enable field and transmit enable.
// - when disabled the pins go back to the port registers and power is minimal.
// - with stop-in-idle set the channel halts in idle mode, else it keeps going.
// - unimplemented mode bits ignore writes and read zero.
// - the pin-enable field is legacy only and pin select overrides it.
`timescale 1ns/1ps
`default_nettype none

module umc_mode_ctrl (
	input  wire logic                 hclk,
	input  wire logic                 hresetn,
	input  wire logic                 hsel,
	input  wire logic [7:0]           haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic      [31:0]          hrdata,
	output logic                      hreadyout,
	output logic                      hresp,
	input  wire umc_pkg::umc_power_t  power,
	input  wire logic                 pin_select_override,
	input  wire logic                 transmit_enable,
	input  wire logic                 chan_busy,
	input  wire logic                 receive_overrun_error,
	output umc_pkg::umc_clkctl_t      clkctl,
	output logic                      rx_shift_enable,
	output logic                      pins_owned,
	output logic                      tx_pin_owned,
	output logic      [1:0]           legacy_pin_mode,
	output logic      [31:0]          mode_fields
);

	// ****************************************
	// bus slave
	// ****************************************
	logic [31:0] mode_q;
	logic [31:0] mode_d;
	logic        wr_pend_q;
	logic [7:0]  addr_q;
	logic [31:0] hrdata_q;
	logic        active;
	logic        brg_run;
	logic        chan_run;
	logic        ovr_seen_q;
	logic [31:0] rdata_d;
	logic        take;
	logic        mode_wr;
	logic        mode_wr_ok;
	logic        sel_mode;
	logic        sel_status;

	assign take = hsel && hready && htrans == umc_pkg::HTRANS_NONSEQ;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// address phase is kept; the write data follows one cycle later
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_q <= 1'b0;
			addr_q    <= 8'h00;
		end
		else
		begin
			wr_pend_q <= take && hwrite;
			if (take)
			begin
				addr_q <= haddr;
			end
		end
	end

	assign mode_wr    = wr_pend_q && addr_q == umc_pkg::MODE_ADDR;
	// writes during activity are dropped: guards software that ignores the status bit
	assign mode_wr_ok = mode_wr && !active;

	always_comb
	begin
		mode_d = mode_q;
		if (mode_wr_ok)
		begin
			mode_d = hwdata & umc_pkg::MODE_WMASK;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			mode_q <= umc_pkg::MODE_RESET;
		else
			mode_q <= mode_d;
	end

	// ****************************************
	// read path
	// ****************************************
	// decoded in the address phase so the data phase is driven from a flop;
	// mode_d forwards a write still in its data phase to a read right behind it
	assign sel_mode   = haddr == umc_pkg::MODE_ADDR;
	assign sel_status = haddr == umc_pkg::STATUS_ADDR;

	always_comb
	begin
		rdata_d = 32'h0000_0000;
		if (sel_mode)
		begin
			rdata_d = mode_d;
			rdata_d[umc_pkg::ACTIVE_BIT] = active;
		end
		else if (sel_status)
		begin
			rdata_d[umc_pkg::ST_BRG_RUN_BIT]  = brg_run;
			rdata_d[umc_pkg::ST_CHAN_RUN_BIT] = chan_run;
			rdata_d[umc_pkg::ST_OVR_BIT]      = ovr_seen_q;
			rdata_d[umc_pkg::ST_PINS_BIT]     = pins_owned;
		end
	end

	// zero outside a read data phase so a stray sample shows nothing stale
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata_q <= 32'h0000_0000;
		else if (take && !hwrite)
			hrdata_q <= rdata_d;
		else
			hrdata_q <= 32'h0000_0000;
	end

	assign hrdata = hrdata_q;

	// ****************************************
	// clock and run control
	// ****************************************
	logic        enabled;
	logic        sleep_run;
	logic        stop_idle;
	logic        run_ovf;
	umc_pkg::umc_clksrc_t src;

	assign enabled   = mode_q[umc_pkg::ENABLE_BIT];
	assign sleep_run = mode_q[umc_pkg::SLEEP_RUN_BIT];
	assign stop_idle = mode_q[umc_pkg::STOP_IDLE_BIT];
	assign run_ovf   = mode_q[umc_pkg::RUN_ON_OVERFLOW_BIT];
	assign src = umc_pkg::umc_clksrc_t'(mode_q[umc_pkg::CLKSRC_LO +: 2]);

	always_comb
	begin
		brg_run = enabled;
		if (power.deep_sleep_mode)
			brg_run = 1'b0;
		else if (power.sleep_mode)
			brg_run = enabled && sleep_run && src == umc_pkg::CLK_FAST_OSC;
		else if (power.idle_mode && stop_idle)
			brg_run = 1'b0;
	end

	assign chan_run = brg_run;
	assign active   = chan_run && chan_busy;

	always_comb
	begin
		clkctl.brg_clk_run = brg_run;
		clkctl.chan_run    = chan_run;
		case (src)
			umc_pkg::CLK_PB2:          clkctl.brg_clk_sel = umc_pkg::CLK_PB2;
			umc_pkg::CLK_FAST_OSC:     clkctl.brg_clk_sel = umc_pkg::CLK_FAST_OSC;
			umc_pkg::CLK_SYS_SLEEPOFF: clkctl.brg_clk_sel = umc_pkg::CLK_SYS_SLEEPOFF;
			default:                   clkctl.brg_clk_sel = umc_pkg::CLK_PB2_SLEEPOFF;
		endcase
	end

	// ****************************************
	// overrun handling
	// ****************************************
	// set wins over the clear made while the enable bit is clear
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			ovr_seen_q <= 1'b0;
		else if (receive_overrun_error)
			ovr_seen_q <= 1'b1;
		else if (!enabled)
			ovr_seen_q <= 1'b0;
	end

	assign rx_shift_enable = chan_run && (run_ovf || !(ovr_seen_q || receive_overrun_error));

	// ****************************************
	// pin ownership
	// ****************************************
	assign pins_owned      = enabled;
	assign tx_pin_owned    = enabled && transmit_enable;
	// pin select wins; field only reaches the port when not overridden
	assign legacy_pin_mode = (enabled && !pin_select_override)
		? mode_q[umc_pkg::PIN_EN_LO +: 2] : 2'b00;
	assign mode_fields     = mode_q;

	// ****************************************
	// elaboration checks
	// ****************************************
	// the package is shared; a bad edit there must stop the build, not shift the map
	if (umc_pkg::CLKSRC_LO + 2 > $bits(mode_q))
	begin : g_bad_clksrc
		$error("clock source field lies outside the mode word");
	end
	if (umc_pkg::PIN_EN_LO + 2 > $bits(mode_q))
	begin : g_bad_pin_en
		$error("pin enable field lies outside the mode word");
	end
	if (umc_pkg::SLEEP_RUN_BIT >= $bits(mode_q))
	begin : g_bad_sleep_run
		$error("sleep run bit lies outside the mode word");
	end
	if (umc_pkg::ACTIVE_BIT >= $bits(mode_q))
	begin : g_bad_active
		$error("activity bit lies outside the mode word");
	end
	if (umc_pkg::MODE_WMASK[umc_pkg::ACTIVE_BIT] != 1'b0)
	begin : g_active_writable
		$error("activity bit must not be writable");
	end
	if ((umc_pkg::MODE_RESET & ~umc_pkg::MODE_WMASK) != 32'h0000_0000)
	begin : g_bad_reset
		$error("reset value sets bits that cannot be stored");
	end
	if (umc_pkg::MODE_ADDR == umc_pkg::STATUS_ADDR)
	begin : g_addr_clash
		$error("mode and status words share an address");
	end
	if (umc_pkg::ST_PINS_BIT >= $bits(rdata_d))
	begin : g_bad_status
		$error("status bit lies outside the read word");
	end

endmodule : umc_mode_ctrl

`default_nettype wire

// ===== tb/umc_props.sv
`timescale 1ns/1ps
`default_nettype none
module umc_props (
	input wire logic                 hclk,
	input wire logic                 hresetn,
	input wire umc_pkg::umc_power_t  power,
	input wire umc_pkg::umc_clkctl_t clkctl,
	input wire logic                 receive_overrun_error,
	input wire logic                 rx_shift_enable,
	input wire logic                 pins_owned,
	input wire logic [31:0]          mode_fields
);
	// ****
	// checks
	// ****
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	sequence legacy_ovr_s;
		receive_overrun_error && !mode_fields[16];
	endsequence
	sequence fast_sleep_s;
		power == 3'b100 && clkctl.brg_clk_sel == 2'b10 && mode_fields[15];
	endsequence
	AST_DEEP_OFF: assert property (
		power.deep_sleep_mode |-> !clkctl.brg_clk_run && !clkctl.chan_run) else $error("deep run");
	AST_SLEEP_SRC: assert property (
		power.sleep_mode && clkctl.brg_clk_sel != 2'b10 |-> !clkctl.brg_clk_run) else $error("src");
	AST_SLEEP_RUN: assert property (
		fast_sleep_s |-> clkctl.brg_clk_run == mode_fields[23]) else $error("sleep run");
	AST_SRC_SEL: assert property (
		clkctl.brg_clk_sel == mode_fields[18:17]) else $error("clock select");
	AST_UNIMP: assert property (
		(mode_fields & 32'hff78_4000) == 32'h0) else $error("unimplemented bits");
	AST_PINS: assert property (
		pins_owned == mode_fields[15]) else $error("pin ownership");
	AST_OVF_STOP: assert property (
		legacy_ovr_s |-> !rx_shift_enable [*2]) else $error("shifter runs on");
	AST_OVF_KEEP: assert property (
		receive_overrun_error && mode_fields[16] && clkctl.chan_run |-> rx_shift_enable)
		else $error("shifter stopped");
	AST_IDLE: assert property (
		power.idle_mode && mode_fields[13] |-> !clkctl.chan_run) else $error("idle run");
endmodule : umc_props
bind umc_mode_ctrl umc_props props_u (.hclk(hclk), .hresetn(hresetn), .power(power),
	.clkctl(clkctl), .receive_overrun_error(receive_overrun_error),
	.rx_shift_enable(rx_shift_enable), .pins_owned(pins_owned), .mode_fields(mode_fields));
`default_nettype wire

// ===== tb/umc_peer.sv
`timescale 1ns/1ps
`default_nettype none
module umc_peer (
	input wire logic  hclk,
	input wire logic  hresetn,
	input wire logic  go,
	input wire logic  ovf,
	output logic      chan_busy,
	output logic      receive_overrun_error
);
	// ****
	// one frame of ten cycles, overrun on its last
	// ****
	logic [3:0] cnt_q;
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			cnt_q <= 4'h0;
		else
			cnt_q <= go ? 4'ha : cnt_q - {3'h0, cnt_q != 4'h0};
	assign chan_busy = cnt_q != 4'h0;
	assign receive_overrun_error = ovf && cnt_q == 4'h1;
endmodule : umc_peer
`default_nettype wire

// ===== tb/test_uart_mode_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_uart_mode_control;
	typedef struct packed {logic [31:0] wd; logic [2:0] p; logic [31:0] rd; logic run;} umc_row_t;
	localparam umc_row_t rows [9] = '{{32'h0085_8000, 3'h4, 32'h0085_8000, 1'b1},
		{32'h0005_8000, 3'h4, 32'h0005_8000, 1'b0}, {32'h0083_8000, 3'h4, 32'h0083_8000, 1'b0},
		{32'h0087_8000, 3'h4, 32'h0087_8000, 1'b0}, {32'h0081_8000, 3'h4, 32'h0081_8000, 1'b0},
		{32'h0085_8000, 3'h2, 32'h0085_8000, 1'b0}, {32'h0000_a000, 3'h1, 32'h0000_a000, 1'b0},
		{32'h0000_8000, 3'h1, 32'h0000_8000, 1'b1}, {32'hffff_ffff, 3'h0, 32'h0087_bfff, 1'b1}};
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, go = 1'b0, ovf = 1'b0;
	logic pso = 1'b0, txe = 1'b0, hreadyout, busy, ovr, rxe, po, tpo, resp;
	logic [7:0] haddr = 8'h0;
	logic [1:0] htrans = 2'h0, lpm;
	logic [31:0] hwdata = 32'h0, hrdata, rd, mf;
	umc_pkg::umc_power_t pw = 3'h0;
	umc_pkg::umc_clkctl_t ck;
	int n_errors = 0, check_count = 0;
	always #5 hclk = ~hclk;
	umc_peer peer_u (.hclk(hclk), .hresetn(hresetn), .go(go), .ovf(ovf), .chan_busy(busy),
		.receive_overrun_error(ovr));
	umc_mode_ctrl dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(umc_pkg::HSIZE_WORD), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(resp), .power(pw),
		.pin_select_override(pso), .transmit_enable(txe), .chan_busy(busy),
		.receive_overrun_error(ovr), .clkctl(ck), .rx_shift_enable(rxe), .pins_owned(po),
		.tx_pin_owned(tpo), .legacy_pin_mode(lpm), .mode_fields(mf));
	task automatic report_and_stop;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : report_and_stop
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e)
		begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic edge_ready;
		int k;
		for (k = 0; k < 16 && hreadyout !== 1'b1; k++)
			@(posedge hclk);
		@(posedge hclk);
		chk("ready wait", 32'(k), 32'(k % 16));
		if (k == 16)
			report_and_stop();
	endtask : edge_ready
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= umc_pkg::HTRANS_NONSEQ;
		edge_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		edge_ready();
		rd = hrdata;
		chk("resp", 32'(resp), 32'h0);
	endtask : xfer
	task automatic frame;
		go <= 1'b1;
		@(posedge hclk);
		go <= 1'b0;
	endtask : frame
	// ****
	// sequence
	// ****
	initial
	begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		xfer(1'b0, umc_pkg::MODE_ADDR, 32'h0);
		chk("mode reset", rd, 32'h0);
		foreach (rows[i])
		begin
			pw <= rows[i].p;
			xfer(1'b1, umc_pkg::MODE_ADDR, rows[i].wd);
			xfer(1'b0, umc_pkg::MODE_ADDR, 32'h0);
			chk("mode", rd, rows[i].rd);
			chk("brg run", 32'(ck.brg_clk_run), 32'(rows[i].run));
			chk("clk sel", 32'(ck.brg_clk_sel), 32'(rows[i].wd[18:17]));
		end
		pw <= 3'h0;
		xfer(1'b1, umc_pkg::MODE_ADDR, 32'h0000_8000);
		frame();
		xfer(1'b0, umc_pkg::MODE_ADDR, 32'h0);
		chk("active", rd, 32'h0040_8000);
		xfer(1'b1, umc_pkg::MODE_ADDR, 32'h0000_0001);
		repeat (8) @(posedge hclk);
		xfer(1'b0, umc_pkg::MODE_ADDR, 32'h0);
		chk("busy write", rd, 32'h0000_8000);
		ovf <= 1'b1;
		for (int r = 0; r < 2; r++)
		begin
			xfer(1'b1, umc_pkg::MODE_ADDR, 32'h0000_8000 | (32'(r) << 16));
			frame();
			repeat (12) @(posedge hclk);
			chk("rx shift", 32'(rxe), 32'(r));
		end
		xfer(1'b0, umc_pkg::STATUS_ADDR, 32'h0);
		chk("status", rd, 32'h0000_000f);
		txe <= 1'b1;
		xfer(1'b1, umc_pkg::MODE_ADDR, 32'h0000_8300);
		@(posedge hclk);
		chk("pins", {po, tpo, lpm}, 4'hf);
		pso <= 1'b1;
		@(posedge hclk);
		chk("pins select", {po, tpo, lpm}, 4'hc);
		xfer(1'b1, umc_pkg::MODE_ADDR, 32'h0);
		@(posedge hclk);
		chk("pins off", {po, tpo, lpm}, 4'h0);
		xfer(1'b1, 8'h10, 32'hffff_ffff);
		xfer(1'b0, 8'h10, 32'h0);
		chk("unmapped", rd, 32'h0);
		xfer(1'b1, umc_pkg::MODE_ADDR, 32'h0000_00ff);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		xfer(1'b0, umc_pkg::MODE_ADDR, 32'h0);
		chk("mode rereset", rd, 32'h0);
		report_and_stop();
	end
endmodule : test_uart_mode_control
`default_nettype wire
